// ==== hw/pbs_port.sv ====
// Pipelined burst SRAM port: input registers, burst counter, write and read pipeline.
`timescale 1ns/1ps
module pbs_port (
   input  wire logic                         clk,
   input  wire logic                         arst_n,
   input  wire logic [pbs_pkg::ADDR_W-1:0]   addr,
   input  wire logic [pbs_pkg::DATA_W-1:0]   dqIn,
   output logic      [pbs_pkg::DATA_W-1:0]   dqOut,
   output logic                              dqOe,
   input  wire logic                         pipeline_select_n,
   input  wire logic                         depth_select_high,
   input  wire logic                         depth_select_low_n,
   input  wire logic                         processor_addr_strobe_n,
   input  wire logic                         controller_addr_strobe_n,
   input  wire logic                         burst_advance_n,
   input  wire logic [pbs_pkg::LANES-1:0]    lane_write_n,
   input  wire logic                         byte_write_gate_n,
   input  wire logic                         all_lanes_write_n,
   input  wire logic                         burstLinear,
   input  wire logic                         output_enable_n,
   input  wire logic                         sleep_request
);
   typedef struct packed {
      logic [pbs_pkg::ADDR_W-1:0] inAddr;
      logic [pbs_pkg::DATA_W-1:0] inData;
      logic [2:0]                 inSel;
      logic                       inProcStrobeN;
      logic                       inCtrlStrobeN;
      logic                       inAdvanceN;
      logic [pbs_pkg::LANES-1:0]  inLaneN;
      logic                       inGateN;
      logic                       inAllN;
      logic                       inLinear;
      logic [pbs_pkg::ADDR_W-1:0] baseAddr;
      logic [pbs_pkg::BEAT_W-1:0] beat;
      logic                       active;
      logic                       readPend;
      logic                       outValid;
      logic [pbs_pkg::DATA_W-1:0] outData;
   } pbs_state_s;

   pbs_state_s                      state;
   pbs_state_s                      next_state;
   logic [pbs_pkg::DATA_W-1:0]      arrayData;
   logic [pbs_pkg::ADDR_W-1:0]      accessAddr;
   logic [pbs_pkg::LANES-1:0]       laneMask;
   logic                            anyStrobe;
   logic                            selected;
   logic                            startNow;
   logic                            stepNow;
   logic                            accessNow;
   logic                            writeNow;
   logic                            readNow;
   logic [pbs_pkg::BEAT_W-1:0]      beatNow;
   logic [pbs_pkg::BEAT_W-1:0]      lowBits;

   // Burst low bits from start bits and beat number
   function automatic logic [pbs_pkg::BEAT_W-1:0] burstLow(
      input logic                       linear,
      input logic [pbs_pkg::BEAT_W-1:0] start,
      input logic [pbs_pkg::BEAT_W-1:0] beatNum
   );
      logic [pbs_pkg::BEAT_W-1:0] result;
      result = '0;
      if (linear) begin
         result = start + beatNum;
      end else begin
         result = start ^ beatNum;
      end
      return result;
   endfunction

   always_comb begin
      next_state = state;

      next_state.inAddr = addr;
      next_state.inData = dqIn;
      next_state.inSel = {pipeline_select_n, depth_select_high, depth_select_low_n};
      next_state.inProcStrobeN = processor_addr_strobe_n;
      next_state.inCtrlStrobeN = controller_addr_strobe_n;
      next_state.inAdvanceN = burst_advance_n;
      next_state.inLaneN = lane_write_n;
      next_state.inGateN = byte_write_gate_n;
      next_state.inAllN = all_lanes_write_n;
      next_state.inLinear = burstLinear;

      // Selected means first select low, high select high, low select low
      selected = (state.inSel == 3'h2);
      anyStrobe = !state.inProcStrobeN || !state.inCtrlStrobeN;

      startNow = anyStrobe && selected;
      stepNow = !anyStrobe && state.active && !state.inAdvanceN;

      beatNow = state.beat;
      accessAddr = state.baseAddr;
      lowBits = state.baseAddr[pbs_pkg::BEAT_W-1:0];

      if (startNow) begin
         beatNow = pbs_pkg::BEAT_RST;
         accessAddr = state.inAddr;
         next_state.baseAddr = state.inAddr;
         next_state.beat = pbs_pkg::BEAT_RST;
         next_state.active = 1'b1;
      end else if (anyStrobe) begin
         next_state.active = 1'b0;
      end else if (stepNow) begin
         // two bit counter, low bits only
         beatNow = state.beat + 2'h1;
         lowBits = burstLow(state.inLinear, state.baseAddr[pbs_pkg::BEAT_W-1:0], beatNow);
         accessAddr = {state.baseAddr[pbs_pkg::ADDR_W-1:pbs_pkg::BEAT_W], lowBits};
         next_state.beat = beatNow;
      end else begin
         lowBits = burstLow(state.inLinear, state.baseAddr[pbs_pkg::BEAT_W-1:0], state.beat);
         accessAddr = {state.baseAddr[pbs_pkg::ADDR_W-1:pbs_pkg::BEAT_W], lowBits};
      end

      accessNow = startNow || (!anyStrobe && state.active);

      if (!state.inAllN) begin
         laneMask = pbs_pkg::LANE_ALL;
      end else if (!state.inGateN) begin
         laneMask = ~state.inLaneN;
      end else begin
         laneMask = pbs_pkg::LANE_NONE;
      end

      // A processor strobe start is always a read; its write data follow a beat later
      if (startNow && !state.inProcStrobeN) begin
         laneMask = pbs_pkg::LANE_NONE;
      end

      writeNow = accessNow && (laneMask != pbs_pkg::LANE_NONE) && !sleep_request;
      readNow = accessNow && (laneMask == pbs_pkg::LANE_NONE);

      next_state.readPend = readNow;
      next_state.outValid = state.readPend;
      if (state.readPend) begin
         next_state.outData = arrayData;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state.inAddr <= pbs_pkg::ADDR_RST;
         state.inData <= pbs_pkg::DATA_RST;
         state.inSel <= pbs_pkg::SEL_RST;
         state.inProcStrobeN <= 1'b1;
         state.inCtrlStrobeN <= 1'b1;
         state.inAdvanceN <= 1'b1;
         state.inLaneN <= pbs_pkg::LANE_N_RST;
         state.inGateN <= 1'b1;
         state.inAllN <= 1'b1;
         state.inLinear <= 1'b0;
         state.baseAddr <= pbs_pkg::ADDR_RST;
         state.beat <= pbs_pkg::BEAT_RST;
         state.active <= 1'b0;
         state.readPend <= 1'b0;
         state.outValid <= 1'b0;
         state.outData <= pbs_pkg::DATA_RST;
      end else begin
         state <= next_state;
      end
   end

   pbs_mem uArray (
      .clk      (clk),
      .arst_n   (arst_n),
      .writeEn  (writeNow),
      .laneMask (laneMask),
      .readEn   (readNow),
      .addr     (accessAddr),
      .wrData   (state.inData),
      .rdData   (arrayData)
   );

   assign dqOut = state.outData;
   // enable and sleep act without the clock
   // drive only read data with enable low
   assign dqOe = state.outValid && !output_enable_n && !sleep_request;
endmodule

// ==== hw/pbs_pkg.sv ====
// Constants shared by the pipelined burst SRAM port and its array.
// How it works
// - Every synchronous input, including address, data, selects, strobes, advance and writes, is caught in a register on the rising clock edge.
// - A new start address and the select state are taken only at an edge where one of the two address strobes is low, and the master must hold a valid address then.
// - Later burst addresses are made inside the port and step only in cycles where burst advance is low.
// - The burst counter is two bits wide and replaces only the two low address bits of the latched start address.
// - An order input chooses a linear increment order or an interleaved order for the burst counter.
// - A write is launched by the registered address, data and write controls and completes inside without any strobe pulse width.
// - A byte write stores only the lanes whose lane enable is low while the byte write gate is low, from one lane up to all four.
// - A low global write stores all four lanes whatever the lane enables say.
// - Output enable and sleep act on the pins at once, with no clock edge between.
// - Read data passes through an output register one edge after the array access.
// - A four beat burst gives its first word three cycles after the start and each later word one cycle after the one before.
// - A start seen while deselected drops the port out of the selected state after one cycle, with no idle cycles added.
package pbs_pkg;
   localparam int ADDR_W = 19;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam int BEAT_W = 2;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int READ_LATENCY = 3;
   localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
   localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;
   localparam logic [LANES-1:0] LANE_NONE = 4'h0;
   localparam logic [LANES-1:0] LANE_ALL = 4'hF;
   localparam logic [LANES-1:0] LANE_N_RST = 4'hF;
   localparam logic [2:0] SEL_RST = 3'h1;
endpackage

// ==== hw/pbs_mem.sv ====
// Storage array with per-lane write mask and registered read data.
`timescale 1ns/1ps
module pbs_mem (
   input  wire logic                         clk,
   input  wire logic                         arst_n,
   input  wire logic                         writeEn,
   input  wire logic [pbs_pkg::LANES-1:0]    laneMask,
   input  wire logic                         readEn,
   input  wire logic [pbs_pkg::ADDR_W-1:0]   addr,
   input  wire logic [pbs_pkg::DATA_W-1:0]   wrData,
   output logic      [pbs_pkg::DATA_W-1:0]   rdData
);
   logic      [pbs_pkg::DATA_W-1:0] cells [pbs_pkg::DEPTH];
   wire logic [pbs_pkg::DATA_W-1:0] mergedWord;

   // Lanes left out keep their old bits, so the array has a single writer
   genvar lane;
   generate
      for (lane = 0; lane < pbs_pkg::LANES; lane++) begin : gLane
         assign mergedWord[lane*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] = laneMask[lane] ?
            wrData[lane*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] :
            cells[addr][lane*pbs_pkg::LANE_W +: pbs_pkg::LANE_W];
      end
   endgenerate

   // Array cells carry no reset; only the read register does
   always_ff @(posedge clk) begin
      if (writeEn) begin
         cells[addr] <= mergedWord;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdData <= pbs_pkg::DATA_RST;
      end else if (readEn) begin
         rdData <= cells[addr];
      end
   end
endmodule

// ==== bench/pbs_port_sva.sv ====
// Port-level assertions for the pipelined burst SRAM port.
`timescale 1ns/1ps
module pbs_port_sva (
   input wire logic                      clk,
   input wire logic                      arst_n,
   input wire logic                      dqOe,
   input wire logic                      pipeline_select_n,
   input wire logic                      depth_select_high,
   input wire logic                      depth_select_low_n,
   input wire logic                      processor_addr_strobe_n,
   input wire logic                      controller_addr_strobe_n,
   input wire logic                      burst_advance_n,
   input wire logic [pbs_pkg::LANES-1:0] lane_write_n,
   input wire logic                      byte_write_gate_n,
   input wire logic                      all_lanes_write_n,
   input wire logic                      output_enable_n,
   input wire logic                      sleep_request
);
   logic       sel, noWr, idle, rdGo, offGo;
   logic [3:0] upCnt;
   assign sel = !pipeline_select_n && depth_select_high && !depth_select_low_n;
   assign noWr = all_lanes_write_n && (byte_write_gate_n || (&lane_write_n));
   assign idle = processor_addr_strobe_n && controller_addr_strobe_n;
   assign rdGo = sel && (!processor_addr_strobe_n || (!controller_addr_strobe_n && noWr));
   assign offGo = !sel && !idle;
   // Saturating age since reset release, bounds the earliest read word
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n) upCnt <= 4'h0;
      else if (upCnt != 4'hF) upCnt <= upCnt + 4'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   chk_oe_off: assert property (output_enable_n |-> !dqOe)
      else $error("data driven with output enable high");
   chk_sleep_off: assert property (sleep_request |-> !dqOe)
      else $error("data driven during sleep");
   chk_reset_quiet: assert property ($rose(arst_n) |-> !dqOe)
      else $error("data driven at reset release");
   chk_early_none: assert property (dqOe |-> upCnt > 4'h2)
      else $error("read word earlier than the pipeline allows");
   chk_first_beat: assert property (rdGo |-> ##3 (dqOe || output_enable_n))
      else $error("first read word late");
   chk_proc_read: assert property (sel && !processor_addr_strobe_n && !noWr
      |-> ##3 (dqOe || output_enable_n)) else $error("processor strobe start not a read");
   chk_burst_beats: assert property (rdGo ##1 (idle && noWr && !burst_advance_n)[*3]
      |-> (dqOe || output_enable_n)[*4]) else $error("burst words not one per cycle");
   chk_deselect_one: assert property (offGo ##1 idle[*5] |-> !dqOe)
      else $error("activity after deselect");
endmodule
bind pbs_port pbs_port_sva i_pbs_port_sva (.clk, .arst_n, .dqOe, .pipeline_select_n,
   .depth_select_high, .depth_select_low_n, .processor_addr_strobe_n,
   .controller_addr_strobe_n, .burst_advance_n, .lane_write_n, .byte_write_gate_n,
   .all_lanes_write_n, .output_enable_n, .sleep_request);

// ==== bench/pbs_master.sv ====
// Bus master model: one call drives one clock cycle of the synchronous pins.
`timescale 1ns/1ps
module pbs_master (
   input  wire logic                       clk,
   output logic      [pbs_pkg::ADDR_W-1:0] addr,
   output logic      [pbs_pkg::DATA_W-1:0] dqIn,
   output logic                            pipeline_select_n,
   output logic                            depth_select_high,
   output logic                            depth_select_low_n,
   output logic                            processor_addr_strobe_n,
   output logic                            controller_addr_strobe_n,
   output logic                            burst_advance_n,
   output logic      [pbs_pkg::LANES-1:0]  lane_write_n,
   output logic                            byte_write_gate_n,
   output logic                            all_lanes_write_n,
   output logic                            burstLinear,
   output logic                            output_enable_n,
   output logic                            sleep_request
);
   initial begin
      {addr, dqIn, burstLinear, sleep_request, output_enable_n} = '0;
      {pipeline_select_n, depth_select_high, depth_select_low_n} = 3'h5;
      {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
      {lane_write_n, byte_write_gate_n, all_lanes_write_n} = 6'h3F;
   end
   task automatic beat(input logic [18:0] a, input logic p, c, s, v, g, b,
                       input logic [3:0] l, input logic [35:0] d);
      @(negedge clk);
      // valid address only at a strobe; a released line shows no stale value
      addr <= (p && c) ? ~addr : a;
      dqIn <= (!g || !b) ? d : ~dqIn;
      {pipeline_select_n, depth_select_high, depth_select_low_n} <= {!s, s, !s};
      {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} <= {p, c, v};
      {lane_write_n, byte_write_gate_n, all_lanes_write_n} <= {l, b, g};
   endtask
endmodule

// ==== bench/pbs_port_tb.sv ====
// Self-checking bench for the pipelined burst SRAM port.
`timescale 1ns/1ps
module pbs_port_tb;
   logic                       clk = 1'h0;
   logic                       arst_n = 1'h0;
   logic [pbs_pkg::ADDR_W-1:0] addr;
   logic [pbs_pkg::DATA_W-1:0] dqIn, dqOut;
   logic [pbs_pkg::LANES-1:0]  lane_write_n;
   logic dqOe, pipeline_select_n, depth_select_high, depth_select_low_n, burst_advance_n;
   logic processor_addr_strobe_n, controller_addr_strobe_n, byte_write_gate_n;
   logic all_lanes_write_n, burstLinear, output_enable_n, sleep_request;
   logic [pbs_pkg::DATA_W-1:0] model [logic [pbs_pkg::ADDR_W-1:0]];
   int                         mismatches = 0;
   int                         checked = 0;
   pbs_master i_pbs_master (.clk, .addr, .dqIn, .pipeline_select_n, .depth_select_high,
      .depth_select_low_n, .processor_addr_strobe_n, .controller_addr_strobe_n,
      .burst_advance_n, .lane_write_n, .byte_write_gate_n, .all_lanes_write_n,
      .burstLinear, .output_enable_n, .sleep_request);
   pbs_port i_pbs_port (.clk, .arst_n, .addr, .dqIn, .dqOut, .dqOe, .pipeline_select_n,
      .depth_select_high, .depth_select_low_n, .processor_addr_strobe_n,
      .controller_addr_strobe_n, .burst_advance_n, .lane_write_n, .byte_write_gate_n,
      .all_lanes_write_n, .burstLinear, .output_enable_n, .sleep_request);
   always #5 clk = ~clk;
   task automatic check(input string what, input logic [35:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [18:0] a, input logic [35:0] d);
      i_pbs_master.beat(a, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 4'hF, d);
      model[a] = d;
   endtask
   // Start with either strobe, then advance each cycle; words checked from cycle 3 on
   task automatic rd(input logic [18:0] a, input logic p, lin, input int n);
      logic [18:0] x;
      i_pbs_master.burstLinear = lin;
      i_pbs_master.beat(a, !p, p, 1'h1, 1'h1, !p, 1'h1, 4'hF, 36'h0);
      for (int i = 1; i < 8; i++) begin
         i_pbs_master.beat(a, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 4'hF, 36'h0);
         x = {a[18:2], lin ? a[1:0] + 2'(i - 3) : a[1:0] ^ 2'(i - 3)};
         if (i > 2 && i < 3 + n) check("read word", dqOut, model[x]);
         if (i > 2 && i < 3 + n) check("drive", 36'(dqOe), 36'h1);
      end
   endtask
   task automatic t_burst;
      for (int o = 0; o < 2; o++) begin
         for (int k = 0; k < 4; k++) wr(19'h12340 + 19'(4 * o + k), 36'(k * 36'h111111111 + o));
         rd(19'h12341 + 19'(4 * o), 1'(o), 1'(1 - o), 4);
      end
      $display("burst orders done");
   endtask
   task automatic t_lanes;
      wr(19'h00777, 36'hFFFFFFFFF);
      // only lanes 1 and 2 enabled by the gate
      i_pbs_master.beat(19'h00777, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 4'h9, 36'h0);
      i_pbs_master.beat(19'h00777, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 4'h0, 36'h0);
      model[19'h00777] = 36'hFF80001FF;
      rd(19'h00777, 1'h0, 1'h1, 1);
      $display("byte lanes done");
   endtask
   task automatic t_async;
      check("drive", 36'(dqOe), 36'h1);
      i_pbs_master.output_enable_n = 1'h1;
      #1 check("drive", 36'(dqOe), 36'h0);
      @(negedge clk) i_pbs_master.output_enable_n = 1'h0;
      #1 check("drive", 36'(dqOe), 36'h1);
      i_pbs_master.sleep_request = 1'h1;
      #1 check("drive", 36'(dqOe), 36'h0);
      @(negedge clk) i_pbs_master.sleep_request = 1'h0;
      $display("async pins done");
   endtask
   task automatic t_desel;
      i_pbs_master.beat(19'h00001, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 4'hF, 36'h0);
      for (int i = 1; i < 7; i++) begin
         i_pbs_master.beat(19'h00001, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 4'hF, 36'h0);
         if (i > 2) check("drive", 36'(dqOe), 36'h0);
      end
      $display("deselect done");
   endtask
   initial begin
      repeat (20) @(negedge clk);
      arst_n = 1'h1;
      t_burst();
      t_lanes();
      t_async();
      t_desel();
      complete_run();
   end
   // Guards against a hung run
   initial begin
      #200000;
      mismatches++;
      complete_run();
   end
endmodule
